// [src/eec_pkg.sv]
// ----------------------------------------------------------------
// Shared constants and carriers for the event counter channel
// ----------------------------------------------------------------
package eec_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_POWER = 8'h00;
   localparam logic [7:0] OFF_PRESCALE = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_FILTER = 8'h0C;
   localparam logic [7:0] OFF_OUTCTL = 8'h10;
   localparam logic [7:0] OFF_TRIGGER = 8'h14;
   localparam logic [7:0] OFF_RUN = 8'h18;
   localparam logic [7:0] OFF_RELOAD = 8'h1C;
   localparam logic [7:0] OFF_COUNT = 8'h20;
   localparam logic [7:0] OFF_CHSTAT = 8'h24;
   // Field positions
   localparam int START_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int PSC_SEL_W = 4;
   localparam int NUM_OPCLK = 4;
   // Reset values
   localparam logic [15:0] PRESCALE_RST = 16'h0000;
   localparam logic [15:0] RELOAD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'hFFFF;
   // Detection edge encodings
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // Samples that must agree before the filter moves
   localparam int NF_DEPTH = 3;

   // Channel mode fields
   typedef struct packed {
      logic [1:0] edge_sel;
      logic [1:0] clk_sel;
   } eec_mode_t;

   // Output control bits, value in bit 0
   typedef struct packed {
      logic style;
      logic polarity;
      logic enable;
      logic value;
   } eec_outctl_t;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } eec_apb_req_t;

   // APB answer to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } eec_apb_rsp_t;
endpackage

// [src/eec_prescaler.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Four operation clock enables from one free running divider
// ----------------------------------------------------------------
module eec_prescaler #(
   parameter int CNT_W = 16,
   parameter int NCLK = 4,
   parameter int SEL_W = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run_en,
   input wire logic [NCLK*SEL_W-1:0] sel,
   output logic [NCLK-1:0] tick
);
   // Divider state, stopped and cleared while the unit is off
   logic [CNT_W-1:0] cnt_q;

   // True when the low n bits of c are all ones
   function automatic logic low_ones(input logic [CNT_W-1:0] c,
                                     input logic [SEL_W-1:0] n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < CNT_W; i++) begin
         if (i < int'(n) && !c[i]) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   // Divider count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else if (!run_en) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Tick i pulses once every 2^sel[i] cycles
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick <= '0;
      end else begin
         for (int k = 0; k < NCLK; k++) begin
            tick[k] <= run_en && low_ones(cnt_q, sel[k*SEL_W +: SEL_W]);
         end
      end
   end
endmodule // eec_prescaler

// [src/eec_event_input.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin synchroniser, optional noise filter and edge detector
// ----------------------------------------------------------------
module eec_event_input #(
   parameter int DEPTH = 3
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic en,
   input wire logic pin_in,
   input wire logic op_tick,
   input wire logic filter_en,
   input wire logic [1:0] edge_sel,
   output logic edge_pulse
);
   import eec_pkg::*;
   logic sync1_q; // First stage, read only by sync2_q
   logic sync2_q;
   logic [DEPTH-1:0] hist_q; // Samples taken on the operation clock
   logic lvl_q; // Level after the filter
   logic lvl_d;
   logic rise;
   logic fall;

   // Two stage synchroniser for the asynchronous pin
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Filter moves only when all samples agree; bypass follows pin
   always_comb begin
      lvl_d = lvl_q;
      if (!filter_en) begin
         lvl_d = sync2_q;
      end else if (&hist_q) begin
         lvl_d = 1'b1;
      end else if (~|hist_q) begin
         lvl_d = 1'b0;
      end
      rise = lvl_d && !lvl_q;
      fall = !lvl_d && lvl_q;
   end

   // Sampling on the operation clock, edge pulse for one cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hist_q <= '0;
         lvl_q <= 1'b0;
         edge_pulse <= 1'b0;
      end else if (!en) begin
         hist_q <= '0;
         lvl_q <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= 1'b0;
         if (op_tick) begin
            hist_q <= {hist_q[DEPTH-2:0], sync2_q};
            lvl_q <= lvl_d;
            case (edge_sel)
               EDGE_FALL: edge_pulse <= fall;
               EDGE_RISE: edge_pulse <= rise;
               EDGE_BOTH: edge_pulse <= rise || fall;
               default: edge_pulse <= fall;
            endcase
         end
      end
   end
endmodule // eec_event_input

// [src/eec_channel.sv]
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Power bit clear: clock stopped, writes ignored
// - Power bit set: clock runs, channel stopped
// - Prescaler register sets four operation clocks
// - Filter enable: 0 bypasses, 1 filters
// - Start trigger starts channel, reads zero
// - Start sets run status, counting begins
// - Start loads count, then awaits edge
// - Each valid edge decrements count
// - At zero: reload, interrupt, keep counting
// - Reload register writable while running
// - Count register readable at any time
// - Channel status register reads nothing
// - Stop trigger clears run status, self-clears
// - Stopped count holds its value
// - Power clear initialises every register
// - Output value 0 drives low, high when polarity is set
// - Output enable 0 blocks counting output
// - Output style 0 is master mode
// - Events per interrupt equal reload plus one
// - New reload value used at next reload
// ----------------------------------------------------------------
// Event counter channel with APB register slave
// ----------------------------------------------------------------
module eec_channel #(
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input eec_pkg::eec_apb_req_t apb_req,
   output eec_pkg::eec_apb_rsp_t apb_rsp,
   input wire logic channel_event_input_pin,
   output logic channel_output,
   output logic channel_interrupt_request,
   output logic channel_run_status
);
   import eec_pkg::*;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic unit_power_enable_bit; // Gates the whole unit
   logic [15:0] prescaler_q; // Four 4-bit divider selects
   eec_mode_t channel_mode_q; // Clock and edge select
   logic filter_q; // Noise filter enable
   eec_outctl_t outctl_q; // Output value, enable, polarity, style
   logic [CNT_W-1:0] reload_q; // Reload data register
   logic [CNT_W-1:0] count_q; // Down counter
   logic [NUM_OPCLK-1:0] op_ticks; // Operation clock enables
   logic op_tick; // Selected operation clock
   logic edge_pulse; // Valid input edge, one cycle
   logic start_wr; // Start trigger written
   logic stop_wr; // Stop trigger written
   logic wr_fire; // Write takes effect this edge
   logic rd_setup; // Read data is captured this edge
   logic [31:0] rd_data; // Decoded read value
   logic rd_hit; // Address is mapped
   logic reload_now; // Count reaches its end on this edge

   // Address compare, used by the write decodes and assertions below; the read mux uses a case
   function automatic logic at(input logic [7:0] off);
      return apb_req.paddr == off;
   endfunction

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // The answer comes one cycle into the access phase; the write
   // lands on the same edge that the master samples pready high.
   assign wr_fire = apb_req.psel && apb_req.penable &&
                    apb_req.pwrite && apb_rsp.pready;
   assign rd_setup = apb_req.psel && apb_req.penable &&
                     !apb_rsp.pready;
   // Registers other than the power bit need the unit powered
   assign start_wr = wr_fire && unit_power_enable_bit &&
                     at(OFF_TRIGGER) &&
                     apb_req.pwdata[START_BIT];
   assign stop_wr = wr_fire && unit_power_enable_bit &&
                    at(OFF_TRIGGER) &&
                    apb_req.pwdata[STOP_BIT];

   // Read mux; trigger bits and channel status always read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      case (apb_req.paddr)
         OFF_POWER: rd_data[0] = unit_power_enable_bit;
         OFF_PRESCALE: rd_data[15:0] = prescaler_q;
         OFF_MODE: rd_data[3:0] = channel_mode_q;
         OFF_FILTER: rd_data[0] = filter_q;
         OFF_OUTCTL: rd_data[3:0] = outctl_q;
         OFF_TRIGGER: rd_data = 32'h0000_0000;
         OFF_RUN: rd_data[0] = channel_run_status;
         OFF_RELOAD: rd_data[CNT_W-1:0] = reload_q;
         OFF_COUNT: rd_data[CNT_W-1:0] = count_q;
         OFF_CHSTAT: rd_data = 32'h0000_0000;
         default: rd_hit = 1'b0;
      endcase
   end

   // Answer register; unmapped addresses get pslverr
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= rd_setup;
         apb_rsp.pslverr <= rd_setup && !rd_hit;
         if (rd_setup) begin
            apb_rsp.prdata <= rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power enable and configuration
   // ----------------------------------------------------------------
   // The power bit is always writable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         unit_power_enable_bit <= 1'b0;
      end else if (wr_fire && at(OFF_POWER)) begin
         unit_power_enable_bit <= apb_req.pwdata[0];
      end
   end

   // Configuration held at reset value while powered off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prescaler_q <= PRESCALE_RST;
         channel_mode_q <= '0;
         filter_q <= 1'b0;
         reload_q <= RELOAD_RST;
      end else if (!unit_power_enable_bit) begin
         prescaler_q <= PRESCALE_RST;
         channel_mode_q <= '0;
         filter_q <= 1'b0;
         reload_q <= RELOAD_RST;
      end else if (wr_fire) begin
         if (at(OFF_PRESCALE)) begin
            prescaler_q <= apb_req.pwdata[15:0];
         end
         if (at(OFF_MODE)) begin
            channel_mode_q <= apb_req.pwdata[3:0];
         end
         if (at(OFF_FILTER)) begin
            filter_q <= apb_req.pwdata[0];
         end
         if (at(OFF_RELOAD)) begin
            reload_q <= apb_req.pwdata[CNT_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation clocks and input edges
   // ----------------------------------------------------------------
   // Divider runs only while the unit is powered
   eec_prescaler #(
      .CNT_W(16),
      .NCLK(NUM_OPCLK),
      .SEL_W(PSC_SEL_W)
   ) u_psc (
      .clk(clk),
      .sys_rst(sys_rst),
      .run_en(unit_power_enable_bit),
      .sel(prescaler_q),
      .tick(op_ticks)
   );

   assign op_tick = op_ticks[channel_mode_q.clk_sel];

   // Pin sampled on the chosen operation clock
   eec_event_input #(
      .DEPTH(NF_DEPTH)
   ) u_in (
      .clk(clk),
      .sys_rst(sys_rst),
      .en(unit_power_enable_bit),
      .pin_in(channel_event_input_pin),
      .op_tick(op_tick),
      .filter_en(filter_q),
      .edge_sel(channel_mode_q.edge_sel),
      .edge_pulse(edge_pulse)
   );

   // ----------------------------------------------------------------
   // Run control and counter
   // ----------------------------------------------------------------
   // Start wins over a stop written in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         channel_run_status <= 1'b0;
      end else if (!unit_power_enable_bit) begin
         channel_run_status <= 1'b0;
      end else if (start_wr) begin
         channel_run_status <= 1'b1;
      end else if (stop_wr) begin
         channel_run_status <= 1'b0;
      end
   end

   // Edges in the start cycle are dropped: the load comes first
   assign reload_now = channel_run_status && !start_wr &&
                       edge_pulse && count_q == '0;

   // Down counter; the reload value is read only at a load, so a
   // rewrite mid period shows up in the next period
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= COUNT_RST;
      end else if (!unit_power_enable_bit) begin
         count_q <= COUNT_RST;
      end else if (start_wr) begin
         count_q <= reload_q;
      end else if (reload_now) begin
         count_q <= reload_q;
      end else if (channel_run_status && edge_pulse) begin
         count_q <= count_q - 1'b1;
      end
      // Otherwise the count is frozen, also after a stop
   end

   // One-cycle interrupt request at each reload from zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         channel_interrupt_request <= 1'b0;
      end else begin
         channel_interrupt_request <= reload_now;
      end
   end

   // ----------------------------------------------------------------
   // Output control
   // ----------------------------------------------------------------
   // Only master style is built, so style is stored but not used to
   // steer anything; counting toggles the value only when enabled.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         outctl_q <= '0;
      end else if (!unit_power_enable_bit) begin
         outctl_q <= '0;
      end else if (wr_fire && at(OFF_OUTCTL)) begin
         outctl_q <= apb_req.pwdata[3:0];
      end else if (reload_now && outctl_q.enable) begin
         outctl_q.value <= !outctl_q.value;
      end
   end

   // Pin follows the value bit, inverted when polarity is set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         channel_output <= 1'b0;
      end else if (!unit_power_enable_bit) begin
         channel_output <= 1'b0;
      end else begin
         channel_output <= outctl_q.value ^ outctl_q.polarity;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_clock_off;
      @(posedge clk) disable iff (sys_rst)
      !unit_power_enable_bit |=> op_ticks == '0;
   endproperty
   a_clock_off: assert property (p_clock_off)
      else $error("operation clock ticks while unit is off");

   property p_power_up_stopped;
      @(posedge clk) disable iff (sys_rst)
      $rose(unit_power_enable_bit) |-> !channel_run_status;
   endproperty
   a_power_up_stopped: assert property (p_power_up_stopped)
      else $error("channel running right after power up");

   property p_off_init;
      @(posedge clk) disable iff (sys_rst)
      !unit_power_enable_bit |=> reload_q == RELOAD_RST &&
         count_q == COUNT_RST && outctl_q == '0;
   endproperty
   a_off_init: assert property (p_off_init)
      else $error("registers not initialised while unit is off");

   property p_start;
      @(posedge clk) disable iff (sys_rst)
      start_wr |=> channel_run_status && count_q == $past(reload_q);
   endproperty
   a_start: assert property (p_start)
      else $error("start did not load count and run");

   property p_decrement;
      @(posedge clk) disable iff (sys_rst)
      channel_run_status && edge_pulse && !start_wr &&
      count_q != '0 |=> count_q == $past(count_q) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement)
      else $error("count did not decrement on an edge");

   property p_reload_irq;
      @(posedge clk) disable iff (sys_rst)
      channel_run_status && edge_pulse && !start_wr &&
      count_q == '0 |=> channel_interrupt_request &&
         count_q == $past(reload_q);
   endproperty
   a_reload_irq: assert property (p_reload_irq)
      else $error("no reload and interrupt at zero");

   property p_stop;
      @(posedge clk) disable iff (sys_rst)
      stop_wr && !start_wr |=> !channel_run_status;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not clear run status");

   property p_frozen;
      @(posedge clk) disable iff (sys_rst)
      !channel_run_status && !start_wr && unit_power_enable_bit
      |=> $stable(count_q);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("count moved while stopped");

   property p_out_blocked;
      @(posedge clk) disable iff (sys_rst)
      !outctl_q.enable && !(wr_fire && at(OFF_OUTCTL)) &&
      unit_power_enable_bit |=> $stable(outctl_q.value);
   endproperty
   a_out_blocked: assert property (p_out_blocked)
      else $error("output changed by counting while disabled");

   property p_count_read;
      @(posedge clk) disable iff (sys_rst)
      rd_setup && at(OFF_COUNT) |=> apb_rsp.pready &&
         apb_rsp.prdata[15:0] == $past(count_q);
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("count read returned wrong value");

   property p_trig_reads_zero;
      @(posedge clk) disable iff (sys_rst)
      rd_setup && (at(OFF_TRIGGER) || at(OFF_CHSTAT))
      |=> apb_rsp.prdata == 32'h0000_0000;
   endproperty
   a_trig_reads_zero: assert property (p_trig_reads_zero)
      else $error("trigger or status register read nonzero");
endmodule // eec_channel

// [verification/eec_event_src.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External event source on the channel input pin
// ----------------------------------------------------------------
module eec_event_src #(
   parameter int HALF = 10
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic go,
   input wire logic [7:0] n_req,
   output logic pin,
   output logic busy
);
   logic [7:0] left_q; // Pulses still owed
   logic [7:0] tmr_q; // Position inside the current pulse
   // Pulse high then low for HALF cycles each; wide enough for the filter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         left_q <= 8'h00;
         tmr_q <= 8'h00;
      end else if (go) begin
         left_q <= n_req;
         tmr_q <= 8'h00;
      end else if (left_q != 8'h00) begin
         if (tmr_q == 8'(2 * HALF - 1)) begin
            tmr_q <= 8'h00;
            left_q <= left_q - 8'h01;
         end else begin
            tmr_q <= tmr_q + 8'h01;
         end
      end
   end
   // Pin idles low between bursts
   assign pin = (left_q != 8'h00) && (tmr_q < 8'(HALF));
   assign busy = (left_q != 8'h00);
endmodule // eec_event_src

// [verification/eec_channel_tb.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the event counter channel
// ----------------------------------------------------------------
module eec_channel_tb;
   import eec_pkg::*;
   logic clk;
   logic sys_rst;
   eec_apb_req_t apb_req; // Bus master request
   eec_apb_rsp_t apb_rsp; // Slave answer
   logic pin, chan_out, irq, run, go, busy;
   logic [7:0] n_req;
   int failures = 0;
   int samples_checked = 0;
   int irqs = 0; // Interrupt pulses seen
   int base;
   eec_channel dut (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .channel_event_input_pin(pin),
      .channel_output(chan_out), .channel_interrupt_request(irq),
      .channel_run_status(run));
   eec_event_src src (.clk(clk), .sys_rst(sys_rst), .go(go),
      .n_req(n_req), .pin(pin), .busy(busy));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Irq is a one-cycle pulse, so count every high sample
   always @(posedge clk) begin
      if (irq === 1'b1) irqs++;
   end
   task automatic wrap_up;
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; pready, read data and error are all taken at
   // the rising edge at which pready is seen high, then released
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (apb_rsp.pready !== 1'b1) begin
         failures++;
         wrap_up();
      end else begin
         r = apb_rsp.prdata;
         e = apb_rsp.pslverr;
         apb_req.psel <= 1'b0;
         apb_req.penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask
   // Ask the source for n rising edges and wait for the burst to end
   task automatic ev(input logic [7:0] n);
      int k;
      k = 0;
      @(posedge clk);
      go <= 1'b1;
      n_req <= n;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy !== 1'b0 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 2000) begin
         failures++;
         wrap_up();
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_power;
      wr(OFF_RELOAD, 32'h5); // Dropped while unpowered
      wr(OFF_POWER, 32'h1);
      rc(OFF_RELOAD, 32'hFFFF);
      chk(run, 0);
      rc(OFF_COUNT, 32'hFFFF);
   endtask
   task automatic t_start;
      // Mode set while stopped: rising edge, op clock 0
      wr(OFF_MODE, 32'h4);
      wr(OFF_OUTCTL, 32'h0);
      wr(OFF_RELOAD, 32'h3);
      wr(OFF_TRIGGER, 32'h1);
      rc(OFF_TRIGGER, 32'h0);
      chk(run, 1);
      rc(OFF_COUNT, 32'h3);
   endtask
   task automatic t_count;
      base = irqs;
      ev(8'h3);
      rc(OFF_COUNT, 32'h0);
      chk(32'(irqs - base), 32'h0);
      ev(8'h1);
      rc(OFF_COUNT, 32'h3);
      chk(32'(irqs - base), 32'h1);
      chk(chan_out, 0);
   endtask
   // Reload rewritten mid-period only matters at the next reload
   task automatic t_rewrite;
      base = irqs;
      wr(OFF_RELOAD, 32'h1);
      rc(OFF_COUNT, 32'h3);
      ev(8'h4);
      rc(OFF_COUNT, 32'h1);
      chk(32'(irqs - base), 32'h1);
   endtask
   task automatic t_stop;
      wr(OFF_TRIGGER, 32'h2);
      rc(OFF_TRIGGER, 32'h0);
      chk(run, 0);
      ev(8'h2);
      rc(OFF_COUNT, 32'h1);
   endtask
   task automatic t_misc;
      logic [31:0] r;
      logic e;
      rc(OFF_CHSTAT, 32'h0);
      apb(1'b0, 8'h40, 32'h0, r, e); // Unmapped address
      chk(e, 1);
      chk(r, 0);
      wr(OFF_OUTCTL, 32'h1);
      rc(OFF_OUTCTL, 32'h1);
      repeat (2) @(negedge clk);
      chk(chan_out, 1);
      wr(OFF_OUTCTL, 32'h0);
      repeat (2) @(negedge clk);
      chk(chan_out, 0);
   endtask
   // Filter on, both edges on the slower op clock 1: each wide pulse
   // gives two events, so four events from reload 1 make two wraps
   task automatic t_filter;
      base = irqs;
      wr(OFF_FILTER, 32'h1);
      rc(OFF_FILTER, 32'h1);
      wr(OFF_PRESCALE, 32'h10);
      rc(OFF_PRESCALE, 32'h10);
      wr(OFF_MODE, 32'h9);
      wr(OFF_TRIGGER, 32'h1);
      ev(8'h2);
      rc(OFF_COUNT, 32'h1);
      chk(32'(irqs - base), 32'h2);
   endtask
   task automatic t_off;
      wr(OFF_POWER, 32'h0);
      repeat (2) @(negedge clk);
      chk(run, 0);
      rc(OFF_RELOAD, 32'hFFFF);
      rc(OFF_PRESCALE, 32'h0);
      rc(OFF_COUNT, 32'hFFFF);
   endtask
   initial begin
      sys_rst = 1'b1;
      apb_req = '0;
      go = 1'b0;
      n_req = 8'h00;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_power();
      t_start();
      t_count();
      t_rewrite();
      t_stop();
      t_misc();
      t_filter();
      t_off();
      wrap_up();
   end
endmodule // eec_channel_tb
